// ---- rtl/mac_indirect_access.sv ----
// Indirect access bridge from the host register port to the MAC register space
`timescale 1ns/100ps
`include "mac_access_cfg.svh"

// Summary of operation
// - MAC registers reached only through staging registers
// - Read address from low and high bytes
// - Read address used for reads only
// - Read result returned in four bytes
// - Read bytes valid once busy bit clears
// - Write value taken from four bytes
// - Write finished when busy bit clears
// - Direction bit one reads, zero writes
// - Write address from separate byte pair
// - Busy plus direction starts, hardware clears

module mac_indirect_access
(
  input  wire logic        MCLK,       // Host interface clock, 50 MHz
  input  wire logic        RST_N,      // Synchronous reset, low
  input  wire logic [9:0]  CPU_ADDR,   // Host register address
  input  wire logic [7:0]  CPU_WDATA,  // Host write data
  input  wire logic        CPU_WR,     // Host write strobe, one cycle
  input  wire logic        CPU_RD,     // Host read strobe, one cycle
  output logic      [7:0]  CPU_RDATA,  // Host read data
  output logic             CPU_RVALID, // Read data valid, one cycle
  output logic      [15:0] MAC_ADDR,   // MAC register address
  output logic      [31:0] MAC_WDATA,  // MAC write value
  output logic             MAC_RD,     // MAC read request
  output logic             MAC_WR,     // MAC write request
  input  wire logic        MAC_ACK,    // MAC answer, one cycle
  input  wire logic [31:0] MAC_RDATA   // MAC read value with answer
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  rd_addr_lo_reg;
  logic [7:0]  rd_addr_hi_reg;
  logic [7:0]  wr_addr_lo_reg;
  logic [7:0]  wr_addr_hi_reg;
  logic [31:0] wr_value_reg;
  logic [31:0] rd_value_reg;
  logic        busy_reg;
  logic        dir_reg;
  logic        launch;
  logic        finish;
  logic [7:0]  rdata_next;

  // Staging write strobes
  logic        wr_hit;
  assign wr_hit = CPU_WR && !busy_reg;

  // ----------------------------------------------------------------
  // Command launch
  // ----------------------------------------------------------------
  // busy bit written starts
  assign launch = CPU_WR && (CPU_ADDR == `OFS_CMD)
                  && CPU_WDATA[`CMD_BIT_BUSY] && !busy_reg;

  // Address staging; writes while busy are dropped to protect the access
  // read and write address bytes
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      rd_addr_lo_reg <= `RST_BYTE;
      rd_addr_hi_reg <= `RST_BYTE;
      wr_addr_lo_reg <= `RST_BYTE;
      wr_addr_hi_reg <= `RST_BYTE;
    end
    else if (wr_hit)
    begin
      if (CPU_ADDR == `OFS_RD_ADDR_LO)
        rd_addr_lo_reg <= CPU_WDATA;
      else if (CPU_ADDR == `OFS_RD_ADDR_HI)
        rd_addr_hi_reg <= CPU_WDATA;
      else if (CPU_ADDR == `OFS_WR_ADDR_LO)
        wr_addr_lo_reg <= CPU_WDATA;
      else if (CPU_ADDR == `OFS_WR_ADDR_HI)
        wr_addr_hi_reg <= CPU_WDATA;
    end
  end

  // Write value staging, byte 0 lowest
  // four write bytes
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      wr_value_reg <= `RST_WORD;
    else if (wr_hit)
    begin
      if (CPU_ADDR == `OFS_WR_VAL_B0)
        wr_value_reg[7:0] <= CPU_WDATA;
      else if (CPU_ADDR == `OFS_WR_VAL_B1)
        wr_value_reg[15:8] <= CPU_WDATA;
      else if (CPU_ADDR == `OFS_WR_VAL_B2)
        wr_value_reg[23:16] <= CPU_WDATA;
      else if (CPU_ADDR == `OFS_WR_VAL_B3)
        wr_value_reg[31:24] <= CPU_WDATA;
    end
  end

  // Command register: host sets busy, the answer clears it
  // hardware clears busy
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      busy_reg <= 1'b0;
      dir_reg  <= 1'b0;
    end
    else if (launch)
    begin
      busy_reg <= 1'b1;
      dir_reg  <= CPU_WDATA[`CMD_BIT_DIR];
    end
    else if (finish)
      busy_reg <= 1'b0;
    else if (wr_hit && CPU_ADDR == `OFS_CMD)
      dir_reg <= CPU_WDATA[`CMD_BIT_DIR];
  end

  // ----------------------------------------------------------------
  // MAC side
  // ----------------------------------------------------------------
  // Address and value frozen at launch
  // address by direction
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      MAC_ADDR  <= `RST_ADDR;
      MAC_WDATA <= `RST_WORD;
    end
    else if (launch)
    begin
      if (CPU_WDATA[`CMD_BIT_DIR])
        MAC_ADDR <= {rd_addr_hi_reg, rd_addr_lo_reg};
      else
        MAC_ADDR <= {wr_addr_hi_reg, wr_addr_lo_reg};
      MAC_WDATA <= wr_value_reg;
    end
  end

  // Sequencer drives the request strobes
  mac_cmd_engine u_engine
  (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .start    (launch),
    .dir_read (CPU_WDATA[`CMD_BIT_DIR]),
    .ack      (MAC_ACK),
    .req_rd   (MAC_RD),
    .req_wr   (MAC_WR),
    .finish   (finish)
  );

  // Read result captured on the answer, same edge as busy clears
  // capture read value
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      rd_value_reg <= `RST_WORD;
    else if (finish && MAC_RD)
      rd_value_reg <= MAC_RDATA;
  end

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  // only staging registers visible
  always_comb
  begin
    rdata_next = `RST_BYTE;
    if (CPU_ADDR == `OFS_RD_ADDR_LO)
      rdata_next = rd_addr_lo_reg;
    else if (CPU_ADDR == `OFS_RD_ADDR_HI)
      rdata_next = rd_addr_hi_reg;
    else if (CPU_ADDR == `OFS_RD_VAL_B0)
      rdata_next = rd_value_reg[7:0];
    else if (CPU_ADDR == `OFS_RD_VAL_B1)
      rdata_next = rd_value_reg[15:8];
    else if (CPU_ADDR == `OFS_RD_VAL_B2)
      rdata_next = rd_value_reg[23:16];
    else if (CPU_ADDR == `OFS_RD_VAL_B3)
      rdata_next = rd_value_reg[31:24];
    else if (CPU_ADDR == `OFS_WR_VAL_B0)
      rdata_next = wr_value_reg[7:0];
    else if (CPU_ADDR == `OFS_WR_VAL_B1)
      rdata_next = wr_value_reg[15:8];
    else if (CPU_ADDR == `OFS_WR_VAL_B2)
      rdata_next = wr_value_reg[23:16];
    else if (CPU_ADDR == `OFS_WR_VAL_B3)
      rdata_next = wr_value_reg[31:24];
    else if (CPU_ADDR == `OFS_WR_ADDR_LO)
      rdata_next = wr_addr_lo_reg;
    else if (CPU_ADDR == `OFS_WR_ADDR_HI)
      rdata_next = wr_addr_hi_reg;
    else if (CPU_ADDR == `OFS_CMD)
      rdata_next = {6'h00, dir_reg, busy_reg};
  end

  // Registered read answer, one cycle after the strobe
  // busy visible to polling
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      CPU_RDATA  <= `RST_BYTE;
      CPU_RVALID <= 1'b0;
    end
    else
    begin
      CPU_RVALID <= CPU_RD;
      if (CPU_RD)
        CPU_RDATA <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // unmapped reads zero
  unmapped_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CPU_RD && (CPU_ADDR < `OFS_RD_ADDR_LO || CPU_ADDR > `OFS_CMD)
    |=> CPU_RVALID && CPU_RDATA == 8'h00)
    else $error("Unmapped read did not return zero");

  read_addr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(MAC_RD) |-> MAC_ADDR == {rd_addr_hi_reg, rd_addr_lo_reg})
    else $error("Read request carries wrong address");

  write_addr_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(MAC_WR) |-> MAC_ADDR == {wr_addr_hi_reg, wr_addr_lo_reg})
    else $error("Write request carries wrong address");

  read_bytes_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CPU_RD && CPU_ADDR == `OFS_RD_VAL_B3
    |=> CPU_RDATA == $past(rd_value_reg[31:24]))
    else $error("Read byte 3 mismatch");

  read_ready_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    MAC_RD && MAC_ACK |=> !busy_reg && rd_value_reg == $past(MAC_RDATA))
    else $error("Read result not ready when busy cleared");

  write_value_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(MAC_WR) |-> MAC_WDATA == wr_value_reg)
    else $error("Write value not packed from staging bytes");

  write_done_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $fell(busy_reg) && !dir_reg |-> $past(MAC_WR && MAC_ACK))
    else $error("Busy cleared before write was taken");

  dir_select_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    launch |=> (MAC_RD == $past(CPU_WDATA[`CMD_BIT_DIR]))
               && (MAC_WR != MAC_RD))
    else $error("Request strobe does not match direction");

  launch_busy_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    launch |=> busy_reg && (MAC_RD || MAC_WR))
    else $error("Launch did not start an access");

  busy_req_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    busy_reg |-> (MAC_RD || MAC_WR))
    else $error("Busy without a standing request");

  status_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CPU_RD && CPU_ADDR == `OFS_CMD
    |=> CPU_RDATA == {6'h00, $past(dir_reg), $past(busy_reg)})
    else $error("Command status read mismatch");

  staging_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    busy_reg |=> $stable(wr_value_reg) && $stable(MAC_ADDR))
    else $error("Staging changed during an access");

  busy_refuse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    busy_reg && CPU_WR |=> $stable(rd_addr_lo_reg) && $stable(rd_addr_hi_reg)
      && $stable(wr_addr_lo_reg) && $stable(wr_addr_hi_reg) && $stable(dir_reg))
    else $error("Staging write accepted while busy");

  read_only_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(MAC_RD && MAC_ACK) |=> $stable(rd_value_reg))
    else $error("Read result changed without a MAC answer");

endmodule

// ---- shared/mac_access_cfg.svh ----
// Offsets, field positions and reset values of the indirect MAC access block
`ifndef MAC_ACCESS_CFG_SVH
`define MAC_ACCESS_CFG_SVH

// ----------------------------------------------------------------
// Host port register offsets
// ----------------------------------------------------------------
`define OFS_RD_ADDR_LO  10'h140
`define OFS_RD_ADDR_HI  10'h141
`define OFS_RD_VAL_B0   10'h142
`define OFS_RD_VAL_B1   10'h143
`define OFS_RD_VAL_B2   10'h144
`define OFS_RD_VAL_B3   10'h145
`define OFS_WR_VAL_B0   10'h146
`define OFS_WR_VAL_B1   10'h147
`define OFS_WR_VAL_B2   10'h148
`define OFS_WR_VAL_B3   10'h149
`define OFS_WR_ADDR_LO  10'h14a
`define OFS_WR_ADDR_HI  10'h14b
`define OFS_CMD         10'h14c

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define CMD_BIT_BUSY    0
`define CMD_BIT_DIR     1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000
`define RST_ADDR        16'h0000

`endif

// ---- shared/mac_access_pkg.sv ----
// Types shared by the indirect MAC access block
package mac_access_pkg;

  // Command sequencer states, one-hot
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_REQ  = 2'b10
  } cmd_state_t;

endpackage

// ---- rtl/mac_cmd_engine.sv ----
// Command sequencer that drives one MAC access and waits for its answer
`timescale 1ns/100ps

module mac_cmd_engine
(
  input  wire logic clk,       // Host interface clock
  input  wire logic rst_n,     // Synchronous reset, low
  input  wire logic start,     // Launch pulse from the command register
  input  wire logic dir_read,  // 1 read, 0 write
  input  wire logic ack,       // MAC answer
  output logic      req_rd,    // Read request to the MAC
  output logic      req_wr,    // Write request to the MAC
  output logic      finish     // Access answered this cycle
);

  mac_access_pkg::cmd_state_t state_reg;
  mac_access_pkg::cmd_state_t state_next;

  // Answer is taken while a request stands
  assign finish = (state_reg == mac_access_pkg::ST_REQ) && ack;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      mac_access_pkg::ST_IDLE:
        if (start)
          state_next = mac_access_pkg::ST_REQ;
      mac_access_pkg::ST_REQ:
        if (ack)
          state_next = mac_access_pkg::ST_IDLE;
      default:
        state_next = mac_access_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_reg <= mac_access_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Request strobes, held until answered
  // direction picks strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      req_rd <= 1'b0;
      req_wr <= 1'b0;
    end
    else if (state_reg == mac_access_pkg::ST_IDLE && start)
    begin
      req_rd <= dir_read;
      req_wr <= !dir_read;
    end
    else if (finish)
    begin
      req_rd <= 1'b0;
      req_wr <= 1'b0;
    end
  end

  req_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req_rd || req_wr) && !ack |=> $stable(req_rd) && $stable(req_wr))
    else $error("MAC request dropped before its answer");

endmodule

// ---- testbench/mac_space_model.sv ----
// Behavioural MAC register space that answers the bridge's requests
`timescale 1ns/100ps

module mac_space_model
(
  input  wire logic        clk,       // Host interface clock
  input  wire logic        rst_n,     // Synchronous reset, low
  input  wire logic [15:0] addr,      // Register address
  input  wire logic [31:0] wdata,     // Write value
  input  wire logic        rd,        // Read request
  input  wire logic        wr,        // Write request
  input  wire logic [7:0]  delay,     // Wait cycles before the answer
  output logic             ack,       // One-cycle answer
  output logic      [31:0] rdata,     // Read value, valid with ack
  output logic      [15:0] seen_addr, // Last written address
  output logic      [31:0] seen_data, // Last written value
  output logic      [7:0]  count      // Accesses answered
);
  logic [7:0] wait_cnt;
  logic       done;

  // Answer each request once; read data is scrambled outside the answer
  always_ff @(posedge clk)
  begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (!rst_n)
    begin
      rdata <= 32'h0000_0000;
      seen_addr <= 16'h0000;
      seen_data <= 32'h0000_0000;
      count <= 8'h00;
      wait_cnt <= 8'h00;
      done <= 1'b0;
    end
    else if (!(rd || wr))
    begin
      wait_cnt <= 8'h00;
      done <= 1'b0;
    end
    else if (!done && wait_cnt == delay)
    begin
      ack <= 1'b1;
      done <= 1'b1;
      count <= count + 8'h01;
      if (rd)
        rdata <= {~addr, addr};
      if (wr)
      begin
        seen_addr <= addr;
        seen_data <= wdata;
      end
    end
    else if (!done)
      wait_cnt <= wait_cnt + 8'h01;
  end
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the indirect MAC access bridge
`timescale 1ns/100ps
`include "mac_access_cfg.svh"

module tb;
  logic        MCLK, RST_N, CPU_WR, CPU_RD, CPU_RVALID, MAC_RD, MAC_WR, MAC_ACK;
  logic [9:0]  CPU_ADDR;
  logic [7:0]  CPU_WDATA, CPU_RDATA, dly, cnt, b, c0;
  logic [15:0] MAC_ADDR, w_addr;
  logic [31:0] MAC_WDATA, MAC_RDATA, w_data;
  int          errors, compares;

  mac_indirect_access DUT (.MCLK(MCLK), .RST_N(RST_N), .CPU_ADDR(CPU_ADDR),
    .CPU_WDATA(CPU_WDATA), .CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_RDATA(CPU_RDATA),
    .CPU_RVALID(CPU_RVALID), .MAC_ADDR(MAC_ADDR), .MAC_WDATA(MAC_WDATA),
    .MAC_RD(MAC_RD), .MAC_WR(MAC_WR), .MAC_ACK(MAC_ACK), .MAC_RDATA(MAC_RDATA));

  mac_space_model mac (.clk(MCLK), .rst_n(RST_N), .addr(MAC_ADDR), .wdata(MAC_WDATA),
    .rd(MAC_RD), .wr(MAC_WR), .delay(dly), .ack(MAC_ACK), .rdata(MAC_RDATA),
    .seen_addr(w_addr), .seen_data(w_data), .count(cnt));

  // Host clock, 20 ns period
  initial
  begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------
  // Host port tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    CPU_ADDR = a;
    CPU_WDATA = d;
    CPU_WR = 1'b1;
    @(negedge MCLK);
    CPU_WR = 1'b0;
    @(negedge MCLK);
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    CPU_ADDR = a;
    CPU_RD = 1'b1;
    @(negedge MCLK);
    CPU_RD = 1'b0;
    d = CPU_RDATA;
    check(CPU_RVALID, 1'b1);
    @(negedge MCLK);
  endtask

  task automatic poll();
    for (int i = 0; i < 60; i++)
    begin
      rd(`OFS_CMD, b);
      if (b[0] === 1'b0)
        break;
    end
    check(b[0], 1'b0);
  endtask

  task automatic final_report();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 'h13f; a <= 'h14d; a++)
    begin
      rd(10'(a), b);
      check(b, 8'h00);
    end
  endtask

  task automatic t_read();
    dly = 8'h04;
    wr(`OFS_RD_ADDR_LO, 8'h34);
    wr(`OFS_RD_ADDR_HI, 8'h12);
    wr(`OFS_WR_ADDR_LO, 8'hef);
    wr(`OFS_WR_ADDR_HI, 8'hbe);
    wr(`OFS_CMD, 8'h03);
    check({MAC_RD, MAC_WR}, 2'b10);
    check(MAC_ADDR, 16'h1234);
    poll();
    check(b, 8'h02);
    for (int i = 0; i < 4; i++)
    begin
      rd(10'(`OFS_RD_VAL_B0 + i), b);
      check(b, 32'hedcb_1234 >> (8 * i) & 32'hff);
    end
  endtask

  task automatic t_write();
    wr(`OFS_WR_VAL_B0, 8'h44);
    wr(`OFS_WR_VAL_B1, 8'h33);
    wr(`OFS_WR_VAL_B2, 8'h22);
    wr(`OFS_WR_VAL_B3, 8'h11);
    wr(`OFS_CMD, 8'h01);
    check({MAC_RD, MAC_WR}, 2'b01);
    check(MAC_ADDR, 16'hbeef);
    check(MAC_WDATA, 32'h1122_3344);
    poll();
    check(w_addr, 16'hbeef);
    check(w_data, 32'h1122_3344);
    wr(`OFS_RD_VAL_B0, 8'hff);
    rd(`OFS_RD_VAL_B0, b);
    check(b, 8'h34);
  endtask

  // Staging writes while busy are dropped
  task automatic t_busy();
    dly = 8'h1e;
    c0 = cnt;
    wr(`OFS_CMD, 8'h03);
    wr(`OFS_RD_ADDR_LO, 8'h55);
    wr(`OFS_CMD, 8'h01);
    rd(`OFS_CMD, b);
    check(b, 8'h03);
    poll();
    check(cnt, c0 + 8'h01);
    rd(`OFS_RD_ADDR_LO, b);
    check(b, 8'h34);
    dly = 8'h00;
    wr(`OFS_CMD, 8'h01);
    poll();
    check(cnt, c0 + 8'h02);
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    errors++;
    final_report();
  end

  // Reset, then the scenarios in turn
  initial
  begin
    errors = 0;
    compares = 0;
    RST_N = 1'b0;
    CPU_WR = 1'b0;
    CPU_RD = 1'b0;
    CPU_ADDR = 10'h000;
    CPU_WDATA = 8'h00;
    dly = 8'h00;
    repeat (2) @(negedge MCLK);
    RST_N = 1'b1;
    t_reset();
    t_read();
    t_write();
    t_busy();
    final_report();
  end
endmodule
